// ===== design/data_mem_pkg.sv
// shared constants and types for the data memory and eeprom access block
package data_mem_pkg;
  // data space layout
  localparam int          REGFILE_SIZE    = 32;
  localparam int          STD_IO_SIZE     = 64;
  localparam int          EXT_IO_SIZE     = 160;
  localparam logic [15:0] REGFILE_BASE    = 16'h0000;
  localparam logic [15:0] STD_IO_BASE     = 16'h0020;
  localparam logic [15:0] EXT_IO_BASE     = 16'h0060;
  localparam logic [15:0] EXT_IO_LAST     = 16'h00FF;
  localparam logic [15:0] SRAM_BASE       = 16'h0100;
  localparam int          SRAM_BYTES_DEF  = 2048;
  localparam int          EE_BYTES_DEF    = 1024;
  localparam int          FLASH_WORDS_DEF = 16384;
  localparam int          FLASH_WORD_W    = 16;
  // pointer pairs: low byte register of x, y, z
  localparam logic [4:0]  PTR_X_LO        = 5'h1A;
  localparam logic [4:0]  PTR_Y_LO        = 5'h1C;
  localparam logic [4:0]  PTR_Z_LO        = 5'h1E;
  localparam logic [5:0]  DISP_MAX        = 6'h3F;
  // eeprom registers, port (standard i/o) numbers
  localparam logic [5:0]  EE_CTRL_PORT    = 6'h1F;
  localparam logic [5:0]  EE_BYTE_PORT    = 6'h20;
  localparam logic [5:0]  EE_ADDRL_PORT   = 6'h21;
  localparam logic [5:0]  EE_ADDRH_PORT   = 6'h22;
  localparam int          EE_ADDR_W       = 10;
  // control register bit positions
  localparam int          CTRL_READ_BIT   = 0;
  localparam int          CTRL_STROBE_BIT = 1;
  localparam int          CTRL_ARM_BIT    = 2;
  localparam int          CTRL_RIE_BIT    = 3;
  localparam int          CTRL_PM_LSB     = 4;
  localparam logic [1:0]  PM_ATOMIC       = 2'h0;
  localparam logic [1:0]  PM_ERASE        = 2'h1;
  localparam logic [1:0]  PM_WRITE        = 2'h2;
  localparam logic [1:0]  PM_RESERVED     = 2'h3;
  localparam logic [1:0]  PM_RESET        = 2'h0;
  // apb windows (paddr[19:18]) and control-window word indices
  localparam logic [1:0]  WIN_DATA        = 2'h0;
  localparam logic [1:0]  WIN_PORT        = 2'h1;
  localparam logic [1:0]  WIN_CTRL        = 2'h2;
  localparam logic [1:0]  WIN_FLASH       = 2'h3;
  localparam logic [15:0] CTRL_PTR_SEL    = 16'h0000;
  localparam logic [15:0] CTRL_IND_DATA   = 16'h0001;
  localparam logic [15:0] CTRL_STATUS     = 16'h0002;
  localparam logic [9:0]  PTR_SEL_RESET   = 10'h000;
  localparam logic [1:0]  AM_PLAIN        = 2'h0;
  localparam logic [1:0]  AM_DISP         = 2'h1;
  localparam logic [1:0]  AM_PREDEC       = 2'h2;
  localparam logic [1:0]  AM_POSTINC      = 2'h3;
  // timing
  localparam logic [1:0]  SRAM_WAIT       = 2'h1;
  localparam logic [2:0]  ARM_WINDOW      = 3'h4;
  localparam logic [2:0]  HALT_READ       = 3'h4;
  localparam logic [2:0]  HALT_WRITE      = 3'h2;
  localparam int          CLK_KHZ         = 25000;
  localparam real         T_ATOMIC_MS     = 3.4;
  localparam real         T_SPLIT_MS      = 1.8;
  localparam int          ATOMIC_CYC      = int'($floor(T_ATOMIC_MS * CLK_KHZ));
  localparam int          SPLIT_CYC       = int'($floor(T_SPLIT_MS * CLK_KHZ));

  typedef enum logic [2:0] {
    RG_REGFILE, RG_STD_IO, RG_EXT_IO, RG_SRAM, RG_NONE
  } region_t;

  typedef enum logic [2:0] {
    KD_DATA, KD_PTR_SEL, KD_STATUS, KD_FLASH, KD_ERR
  } kind_t;

  // one latched bus request
  typedef struct packed {
    logic [15:0] addr;
    logic        wr;
    logic [15:0] wdata;
    logic        ind;
    kind_t       kind;
  } acc_t;
endpackage

// ===== design/data_memory_eeprom_access.sv
// data space decoder, pointer addressing, flash array and eeprom access
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module data_memory_eeprom_access #(
  parameter int SRAM_BYTES    = data_mem_pkg::SRAM_BYTES_DEF,
  parameter int EE_BYTES      = data_mem_pkg::EE_BYTES_DEF,
  parameter int FLASH_WORDS   = data_mem_pkg::FLASH_WORDS_DEF,
  parameter int ATOMIC_CYCLES = data_mem_pkg::ATOMIC_CYC,
  parameter int SPLIT_CYCLES  = data_mem_pkg::SPLIT_CYC,
  parameter int PC_W          = $clog2(FLASH_WORDS)
) (
  // clock and resets
  input  wire logic                                  pclk,
  input  wire logic                                  presetn,
  input  wire logic                                  por_n,
  // apb slave
  input  wire logic [19:0]                           paddr,
  input  wire logic                                  psel,
  input  wire logic                                  penable,
  input  wire logic                                  pwrite,
  input  wire logic [31:0]                           pwdata,
  output logic      [31:0]                           prdata,
  output logic                                       pready,
  output logic                                       pslverr,
  // cpu side
  input  wire logic                                  global_irq_enable,
  input  wire logic                                  flash_selfprog_active,
  input  wire logic [PC_W-1:0]                       program_counter,
  output logic      [data_mem_pkg::FLASH_WORD_W-1:0] fetch_word,
  output logic                                       cpu_halt,
  output logic                                       eeprom_ready_irq,
  output logic                                       eeprom_busy
);
  localparam int SRAM_AW = $clog2(SRAM_BYTES);
  localparam int EE_AW   = $clog2(EE_BYTES);
  localparam int TW      = $clog2(ATOMIC_CYCLES + 1);

  // storage arrays
  logic [7:0]  rf_mem    [0:data_mem_pkg::REGFILE_SIZE-1];
  logic [7:0]  sram_mem  [0:SRAM_BYTES-1];
  logic [7:0]  ee_mem    [0:EE_BYTES-1];
  logic [data_mem_pkg::FLASH_WORD_W-1:0] flash_mem [0:FLASH_WORDS-1];

  data_mem_pkg::acc_t req_d, req_q;
  logic [1:0]                   wait_q;
  logic [2:0]                   halt_d, halt_q;
  logic [9:0]                   ptr_sel_q;
  logic [data_mem_pkg::EE_ADDR_W-1:0] ee_addr_q;
  logic [7:0]                   ee_byte_q;
  logic                         rie_q, arm_q;
  logic [2:0]                   arm_cnt_q;
  logic                         busy_q;
  logic [TW-1:0]                tmr_q;
  logic [1:0]                   eeprom_prog_mode_q, pend_mode_q;
  logic [EE_AW-1:0]             pend_addr_q;
  logic [7:0]                   pend_data_q;
  logic                         done, data_wr, ctrl_wr, ee_start, ee_read;
  logic [15:0]                  ptr, ind_addr, idx;
  logic [4:0]                   ptr_lo;
  logic [7:0]                   rd_byte;
  logic [31:0]                  rd_word;
  logic [SRAM_AW-1:0]           sram_idx;

  // region decode, shared by reads and writes
  function automatic data_mem_pkg::region_t region_of(input logic [15:0] a);
    if (a < data_mem_pkg::STD_IO_BASE) begin
      return data_mem_pkg::RG_REGFILE;
    end else if (a < data_mem_pkg::EXT_IO_BASE) begin
      return data_mem_pkg::RG_STD_IO;
    end else if (a <= data_mem_pkg::EXT_IO_LAST) begin
      return data_mem_pkg::RG_EXT_IO;
    end else if (int'(a) < int'(data_mem_pkg::SRAM_BASE) + SRAM_BYTES) begin
      return data_mem_pkg::RG_SRAM;
    end
    return data_mem_pkg::RG_NONE;
  endfunction

  // low register of the selected pointer pair; code 3 also means z
  function automatic logic [4:0] ptr_reg(input logic [1:0] sel);
    unique case (sel)
      2'h0:    return data_mem_pkg::PTR_X_LO;
      2'h1:    return data_mem_pkg::PTR_Y_LO;
      default: return data_mem_pkg::PTR_Z_LO;
    endcase
  endfunction

  // indirect address from the selected pointer
  always_comb begin
    ptr_lo = ptr_reg(ptr_sel_q[1:0]);
    ptr    = {rf_mem[ptr_lo + 5'h01], rf_mem[ptr_lo]};
    unique case (ptr_sel_q[3:2])
      data_mem_pkg::AM_DISP: begin
        // x has no displacement form, so it is taken as zero there
        if (ptr_lo == data_mem_pkg::PTR_X_LO) begin
          ind_addr = ptr;
        end else begin
          ind_addr = ptr + {10'h000, ptr_sel_q[9:4] & data_mem_pkg::DISP_MAX};
        end
      end
      data_mem_pkg::AM_PREDEC: ind_addr = ptr - 16'h0001;
      default:                 ind_addr = ptr;
    endcase
  end

  // request decode during the setup phase
  always_comb begin
    idx        = paddr[17:2];
    req_d      = '0;
    req_d.wr   = pwrite;
    req_d.wdata = pwdata[15:0];
    req_d.kind = data_mem_pkg::KD_DATA;
    unique case (paddr[19:18])
      data_mem_pkg::WIN_DATA: req_d.addr = idx;
      data_mem_pkg::WIN_PORT: begin
        // port window: only 64 std i/o ports, ext i/o is not reachable
        if (idx < 16'(data_mem_pkg::STD_IO_SIZE)) begin
          req_d.addr = idx + data_mem_pkg::STD_IO_BASE;
        end else begin
          req_d.kind = data_mem_pkg::KD_ERR;
        end
      end
      data_mem_pkg::WIN_CTRL: begin
        if (idx == data_mem_pkg::CTRL_IND_DATA) begin
          req_d.addr = ind_addr;
          req_d.ind  = 1'b1;
        end else if (idx == data_mem_pkg::CTRL_PTR_SEL) begin
          req_d.kind = data_mem_pkg::KD_PTR_SEL;
        end else if (idx == data_mem_pkg::CTRL_STATUS) begin
          req_d.kind = data_mem_pkg::KD_STATUS;
        end else begin
          req_d.kind = data_mem_pkg::KD_ERR;
        end
      end
      default: begin
        req_d.addr = idx;
        if (int'(idx) < FLASH_WORDS) begin
          req_d.kind = data_mem_pkg::KD_FLASH;
        end else begin
          req_d.kind = data_mem_pkg::KD_ERR;
        end
      end
    endcase
  end

  // read data for the latched request
  always_comb begin
    rd_byte  = 8'h00;
    sram_idx = SRAM_AW'(req_q.addr - data_mem_pkg::SRAM_BASE);
    unique case (region_of(req_q.addr))
      data_mem_pkg::RG_REGFILE: rd_byte = rf_mem[req_q.addr[4:0]];
      data_mem_pkg::RG_STD_IO: begin
        unique case (req_q.addr[5:0] - data_mem_pkg::STD_IO_BASE[5:0])
          data_mem_pkg::EE_CTRL_PORT: begin
            rd_byte = {2'h0, eeprom_prog_mode_q, rie_q, arm_q, busy_q, 1'b0};
          end
          data_mem_pkg::EE_BYTE_PORT:  rd_byte = ee_byte_q;
          data_mem_pkg::EE_ADDRL_PORT: rd_byte = ee_addr_q[7:0];
          data_mem_pkg::EE_ADDRH_PORT: rd_byte = {6'h00, ee_addr_q[9:8]};
          default:                     rd_byte = 8'h00;
        endcase
      end
      data_mem_pkg::RG_SRAM: rd_byte = sram_mem[sram_idx];
      default:               rd_byte = 8'h00;
    endcase
    unique case (req_q.kind)
      data_mem_pkg::KD_PTR_SEL: rd_word = {22'h000000, ptr_sel_q};
      data_mem_pkg::KD_STATUS:  rd_word = {26'h0000000, busy_q, arm_q, arm_cnt_q[1:0], halt_q[1:0]};
      data_mem_pkg::KD_FLASH:   rd_word = {16'h0000, flash_mem[PC_W'(req_q.addr)]};
      data_mem_pkg::KD_ERR:     rd_word = 32'h00000000;
      default:                  rd_word = {24'h000000, rd_byte};
    endcase
  end

  // completion and eeprom control strobes
  assign done     = psel && penable && pready;
  assign data_wr  = done && req_q.wr && req_q.kind == data_mem_pkg::KD_DATA;
  assign ctrl_wr  = data_wr && req_q.addr == 16'(data_mem_pkg::EE_CTRL_PORT) + data_mem_pkg::STD_IO_BASE;
  // start needs the arm bit still up, an idle engine and a legal mode
  assign ee_start = ctrl_wr && req_q.wdata[data_mem_pkg::CTRL_STROBE_BIT] && arm_q && !busy_q
                    && !flash_selfprog_active && eeprom_prog_mode_q != data_mem_pkg::PM_RESERVED;
  assign ee_read  = ctrl_wr && req_q.wdata[data_mem_pkg::CTRL_READ_BIT] && !busy_q;

  // apb handshake: sram takes one wait cycle, eeprom halt holds off the answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_q   <= '0;
      wait_q  <= 2'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready <= 1'b0;
      if (psel && !penable) begin
        req_q <= req_d;
        if (req_d.kind == data_mem_pkg::KD_DATA && region_of(req_d.addr) == data_mem_pkg::RG_SRAM) begin
          wait_q <= data_mem_pkg::SRAM_WAIT;
        end else begin
          wait_q <= 2'h0;
        end
      end else if (psel && penable && !pready) begin
        if (wait_q != 2'h0) begin
          wait_q <= wait_q - 2'h1;
        end else if (halt_q == 3'h0) begin
          pready  <= 1'b1;
          pslverr <= req_q.kind == data_mem_pkg::KD_ERR;
          prdata  <= rd_word;
        end
      end
    end
  end

  // cpu halt after an eeprom read or write start
  always_comb begin
    halt_d = halt_q;
    if (ee_read) begin
      halt_d = data_mem_pkg::HALT_READ;
    end else if (ee_start) begin
      halt_d = data_mem_pkg::HALT_WRITE;
    end else if (halt_q != 3'h0) begin
      halt_d = halt_q - 3'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_q   <= 3'h0;
      cpu_halt <= 1'b0;
    end else begin
      halt_q   <= halt_d;
      cpu_halt <= halt_d != 3'h0;
    end
  end

  // pointer mode register and eeprom registers on the system reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_sel_q <= data_mem_pkg::PTR_SEL_RESET;
      ee_addr_q <= '0;
      ee_byte_q <= 8'h00;
      rie_q     <= 1'b0;
    end else begin
      if (done && req_q.wr && req_q.kind == data_mem_pkg::KD_PTR_SEL) begin
        ptr_sel_q <= req_q.wdata[9:0];
      end
      if (data_wr && region_of(req_q.addr) == data_mem_pkg::RG_STD_IO) begin
        unique case (req_q.addr[5:0] - data_mem_pkg::STD_IO_BASE[5:0])
          data_mem_pkg::EE_BYTE_PORT:  ee_byte_q <= req_q.wdata[7:0];
          data_mem_pkg::EE_ADDRL_PORT: ee_addr_q[7:0] <= req_q.wdata[7:0];
          data_mem_pkg::EE_ADDRH_PORT: ee_addr_q[9:8] <= req_q.wdata[1:0];
          data_mem_pkg::EE_CTRL_PORT:  rie_q <= req_q.wdata[data_mem_pkg::CTRL_RIE_BIT];
          default: ;
        endcase
      end
      if (ee_read) begin
        ee_byte_q <= ee_mem[EE_AW'(ee_addr_q)];
      end
    end
  end

  // arm bit: set only with strobe written zero, drops four cycles later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_q     <= 1'b0;
      arm_cnt_q <= 3'h0;
    end else if (ctrl_wr && req_q.wdata[data_mem_pkg::CTRL_ARM_BIT]
                 && !req_q.wdata[data_mem_pkg::CTRL_STROBE_BIT]) begin
      arm_q     <= 1'b1;
      arm_cnt_q <= data_mem_pkg::ARM_WINDOW;
    end else if (arm_cnt_q != 3'h0) begin
      arm_cnt_q <= arm_cnt_q - 3'h1;
      if (arm_cnt_q == 3'h1) begin
        arm_q <= 1'b0;
      end
    end
  end

  // write engine on power-on reset only, so a system reset cannot cut a write
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      busy_q      <= 1'b0;
      tmr_q       <= '0;
      eeprom_prog_mode_q      <= data_mem_pkg::PM_RESET;
      pend_mode_q <= data_mem_pkg::PM_ATOMIC;
      pend_addr_q <= '0;
      pend_data_q <= 8'h00;
      eeprom_busy <= 1'b0;
    end else begin
      if (!presetn && !busy_q) begin
        eeprom_prog_mode_q <= data_mem_pkg::PM_RESET;
      end else if (ctrl_wr && !busy_q) begin
        eeprom_prog_mode_q <= req_q.wdata[data_mem_pkg::CTRL_PM_LSB +: 2];
      end
      if (ee_start) begin
        busy_q      <= 1'b1;
        eeprom_busy <= 1'b1;
        pend_mode_q <= eeprom_prog_mode_q;
        pend_addr_q <= EE_AW'(ee_addr_q);
        pend_data_q <= ee_byte_q;
        if (eeprom_prog_mode_q == data_mem_pkg::PM_ATOMIC) begin
          tmr_q <= TW'(ATOMIC_CYCLES - 1);
        end else begin
          tmr_q <= TW'(SPLIT_CYCLES - 1);
        end
      end else if (busy_q) begin
        if (tmr_q == '0) begin
          busy_q      <= 1'b0;
          eeprom_busy <= 1'b0;
        end else begin
          tmr_q <= tmr_q - TW'(1);
        end
      end
    end
  end

  // eeprom cell update when the programming time has run out
  always_ff @(posedge pclk) begin
    if (busy_q && tmr_q == '0) begin
      unique case (pend_mode_q)
        data_mem_pkg::PM_ERASE: ee_mem[pend_addr_q] <= 8'hFF;
        data_mem_pkg::PM_WRITE: ee_mem[pend_addr_q] <= ee_mem[pend_addr_q] & pend_data_q;
        default:                ee_mem[pend_addr_q] <= pend_data_q;
      endcase
    end
  end

  // register file and sram; pointer write-back wins over a data write
  always_ff @(posedge pclk) begin
    if (data_wr && region_of(req_q.addr) == data_mem_pkg::RG_REGFILE) begin
      rf_mem[req_q.addr[4:0]] <= req_q.wdata[7:0];
    end
    if (data_wr && region_of(req_q.addr) == data_mem_pkg::RG_SRAM) begin
      sram_mem[sram_idx] <= req_q.wdata[7:0];
    end
    if (done && req_q.ind && ptr_sel_q[3:2] == data_mem_pkg::AM_PREDEC) begin
      {rf_mem[ptr_lo + 5'h01], rf_mem[ptr_lo]} <= ind_addr;
    end else if (done && req_q.ind && ptr_sel_q[3:2] == data_mem_pkg::AM_POSTINC) begin
      {rf_mem[ptr_lo + 5'h01], rf_mem[ptr_lo]} <= ptr + 16'h0001;
    end
  end

  // program flash: loaded over apb, fetched by program counter
  always_ff @(posedge pclk) begin
    if (done && req_q.wr && req_q.kind == data_mem_pkg::KD_FLASH) begin
      flash_mem[PC_W'(req_q.addr)] <= req_q.wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetch_word       <= '0;
      eeprom_ready_irq <= 1'b0;
    end else begin
      fetch_word       <= flash_mem[program_counter];
      // level request, no flag: drops while a write or self-programming runs
      eeprom_ready_irq <= rie_q && global_irq_enable && !busy_q
                          && !flash_selfprog_active;
    end
  end
endmodule
`default_nettype wire

// ===== sim/cpu_fetch_model.sv
// fetch side model of the cpu core
`timescale 1ns/1ps
`default_nettype none
module cpu_fetch_model #(
  parameter int PC_W = 8
) (
  // clock and reset
  input  wire logic            pclk,
  input  wire logic            presetn,
  // fetch
  input  wire logic            cpu_halt,
  input  wire logic [PC_W-1:0] target_pc,
  output logic      [PC_W-1:0] program_counter
);
  // a halted core must not move on to its next fetch
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) program_counter <= '0;
    else if (!cpu_halt) program_counter <= target_pc;
endmodule
`default_nettype wire

// ===== sim/data_mem_properties.sv
// port checks for the data memory block
`timescale 1ns/1ps
`default_nettype none
module data_mem_checker #(
  parameter int ATOMIC_CYCLES = 20,
  parameter int SPLIT_CYCLES  = 10
) (
  // clock and resets
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        por_n,
  // apb
  input wire logic [19:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // cpu side
  input wire logic        global_irq_enable,
  input wire logic        flash_selfprog_active,
  input wire logic        cpu_halt,
  input wire logic        eeprom_ready_irq,
  input wire logic        eeprom_busy
);
  logic [2:0]  halt_q;
  logic [15:0] busy_q;
  wire  [15:0] idx = paddr[17:2];
  wire  [1:0]  win = paddr[19:18];
  // halt run length
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) halt_q <= 3'h0;
    else halt_q <= cpu_halt ? halt_q + 3'h1 : 3'h0;
  // busy run length; power-on is the only reset that clears it, as busy outlives system reset
  always_ff @(posedge pclk or negedge por_n)
    if (!por_n) busy_q <= 16'h0000;
    else busy_q <= eeprom_busy ? busy_q + 16'h0001 : 16'h0000;
  property p_halt;
    @(posedge pclk) disable iff (!presetn)
    $fell(cpu_halt) |-> halt_q == 3'h2 || halt_q == 3'h4;
  endproperty
  a_halt: assert property (p_halt) else $error("halt len");
  property p_busy;
    @(posedge pclk) disable iff (!por_n || !presetn)
    $fell(eeprom_busy) |-> busy_q inside {[ATOMIC_CYCLES-1:ATOMIC_CYCLES+1],
                                          [SPLIT_CYCLES-1:SPLIT_CYCLES+1]};
  endproperty
  a_busy: assert property (p_busy) else $error("busy len");
  property p_keep;
    @(posedge pclk) disable iff (!por_n)
    !presetn && eeprom_busy && busy_q < 16'h0008 |=> eeprom_busy;
  endproperty
  a_keep: assert property (p_keep) else $error("write lost");
  property p_irq;
    @(posedge pclk) disable iff (!presetn)
    eeprom_busy || !global_irq_enable || flash_selfprog_active
      |=> !eeprom_ready_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq gating");
  property p_rdy;
    @(posedge pclk) disable iff (!presetn)
    pready |-> (psel && penable) ##1 !pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("pready");
  property p_sram;
    @(posedge pclk) disable iff (!presetn)
    psel && $rose(penable) && win == 2'h0 && idx >= 16'h0100
      |-> !pready ##1 !pready;
  endproperty
  a_sram: assert property (p_sram) else $error("sram wait");
  property p_port;
    @(posedge pclk) disable iff (!presetn)
    psel && penable && pready && win == 2'h1 |-> pslverr == (idx > 16'h003F);
  endproperty
  a_port: assert property (p_port) else $error("port range");
  property p_ext;
    @(posedge pclk) disable iff (!presetn)
    pready && !pwrite && win == 2'h0 && idx >= 16'h0060 && idx <= 16'h00FF
      |-> prdata == 32'h00000000 && !pslverr;
  endproperty
  a_ext: assert property (p_ext) else $error("ext io read");
endmodule
bind data_memory_eeprom_access data_mem_checker #(
  .ATOMIC_CYCLES(ATOMIC_CYCLES), .SPLIT_CYCLES(SPLIT_CYCLES)
) chk (
  .pclk(pclk), .presetn(presetn), .por_n(por_n), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .global_irq_enable(global_irq_enable),
  .flash_selfprog_active(flash_selfprog_active), .cpu_halt(cpu_halt),
  .eeprom_ready_irq(eeprom_ready_irq), .eeprom_busy(eeprom_busy)
);
`default_nettype wire

// ===== sim/tb_top.sv
// self-checking bench for the data memory and eeprom block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        pclk, presetn, por_n, psel, penable, pwrite, pready, pslverr;
  logic        gie, selfprog, halt, irq, busy, e;
  logic [19:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] fetch_word;
  logic [7:0]  target_pc, pc;
  int          errors, comparisons;
  data_memory_eeprom_access #(
    .FLASH_WORDS(256), .ATOMIC_CYCLES(20), .SPLIT_CYCLES(10)
  ) DUT (
    .pclk(pclk), .presetn(presetn), .por_n(por_n), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .global_irq_enable(gie), .flash_selfprog_active(selfprog),
    .program_counter(pc), .fetch_word(fetch_word), .cpu_halt(halt),
    .eeprom_ready_irq(irq), .eeprom_busy(busy)
  );
  cpu_fetch_model #(.PC_W(8)) cpu (
    .pclk(pclk), .presetn(presetn), .cpu_halt(halt),
    .target_pc(target_pc), .program_counter(pc)
  );
  // clock, 40 ns period
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic check(input logic [31:0] got, x, input string m);
    comparisons++;
    if (got !== x) begin
      errors++;
      $display("wrong value at %0t: %s %h not %h", $time, m, got, x);
    end
  endtask
  // one transfer; the request holds until pready is seen high, for at most 100 cycles
  task automatic apb(input logic w, input logic [1:0] wn,
                     input logic [15:0] ix, d);
    int n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {wn, ix, 2'h0};
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    // a slave that never answers counts as a mismatch
    if (pready !== 1'b1) errors++;
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [1:0] wn, input logic [15:0] ix, d);
    apb(1'b1, wn, ix, d);
  endtask
  task automatic rd_chk(input logic [1:0] wn, input logic [15:0] ix,
                        input logic [31:0] x, input string m);
    apb(1'b0, wn, ix, 16'h0000);
    check(r, x, m);
  endtask
  // arm with strobe zero, then strobe while still armed
  task automatic ee_start(input logic [15:0] a, d, pm);
    wr(2'h1, 16'h0021, a);
    wr(2'h1, 16'h0020, d);
    wr(2'h1, 16'h001F, pm | 16'h0004);
    wr(2'h1, 16'h001F, pm | 16'h0006);
    repeat (2) @(posedge pclk);
  endtask
  task automatic ee_wait();
    for (int n = 0; n < 200 && busy !== 1'b0; n++) @(posedge pclk);
    if (busy !== 1'b0) errors++;
  endtask
  task automatic ee_rd(input logic [15:0] a, input logic [31:0] x,
                       input string m);
    wr(2'h1, 16'h0021, a);
    wr(2'h1, 16'h001F, 16'h0001);
    rd_chk(2'h1, 16'h0020, x, m);
  endtask
  task automatic t_map();
    wr(2'h0, 16'h0005, 16'h0011);
    rd_chk(2'h0, 16'h0005, 32'h11, "regfile");
    // plain std i/o holes read zero, so go through the eeprom byte port
    wr(2'h1, 16'h0020, 16'h0022);
    rd_chk(2'h0, 16'h0040, 32'h22, "port");
    rd_chk(2'h1, 16'h0010, 32'h0, "std hole");
    wr(2'h0, 16'h0100, 16'h0033);
    rd_chk(2'h0, 16'h0100, 32'h33, "sram lo");
    wr(2'h0, 16'h08FF, 16'h0044);
    rd_chk(2'h0, 16'h08FF, 32'h44, "sram hi");
    wr(2'h0, 16'h0080, 16'h0055);
    rd_chk(2'h0, 16'h0080, 32'h0, "ext io");
    apb(1'b0, 2'h1, 16'h0040, 16'h0000);
    check(e, 1'b1, "port 64");
    $display("map done");
  endtask
  task automatic t_ptr();
    wr(2'h0, 16'h001C, 16'h0020);
    wr(2'h0, 16'h001D, 16'h0001);
    wr(2'h0, 16'h015F, 16'h00AB);
    wr(2'h2, 16'h0000, 16'h03F5); // y plus 63
    rd_chk(2'h2, 16'h0001, 32'hAB, "disp");
    wr(2'h0, 16'h001A, 16'h0030);
    wr(2'h0, 16'h001B, 16'h0001);
    wr(2'h2, 16'h0000, 16'h000C); // x post-increment
    wr(2'h2, 16'h0001, 16'h005A);
    rd_chk(2'h0, 16'h0130, 32'h5A, "postinc");
    rd_chk(2'h0, 16'h001A, 32'h31, "x back");
    wr(2'h0, 16'h001E, 16'h0040);
    wr(2'h0, 16'h001F, 16'h0001);
    wr(2'h2, 16'h0000, 16'h000A); // z pre-decrement
    wr(2'h2, 16'h0001, 16'h0077);
    rd_chk(2'h0, 16'h013F, 32'h77, "predec");
    rd_chk(2'h0, 16'h001E, 32'h3F, "z back");
    $display("pointer done");
  endtask
  task automatic t_ee();
    logic [15:0] pm [3] = '{16'h0000, 16'h0020, 16'h0010};
    logic [15:0] dv [3] = '{16'h003C, 16'h00F0, 16'h0000};
    logic [31:0] xv [3] = '{32'h3C, 32'h30, 32'hFF};
    wr(2'h1, 16'h0022, 16'h0001);
    for (int i = 0; i < 3; i++) begin
      ee_start(16'h0005, dv[i], pm[i]);
      check(busy, 1'b1, "busy");
      apb(1'b0, 2'h1, 16'h001F, 16'h0000);
      check(r & 32'h2, 32'h2, "strobe");
      wr(2'h1, 16'h001F, 16'h0030);
      ee_wait();
      apb(1'b0, 2'h1, 16'h001F, 16'h0000);
      check(r & 32'h30, {16'h0000, pm[i]}, "mode kept");
      ee_rd(16'h0005, xv[i], "mode");
    end
    ee_start(16'h0005, 16'h0011, 16'h0030);
    check(busy, 1'b0, "reserved");
    wr(2'h1, 16'h001F, 16'h0004);
    rd_chk(2'h1, 16'h001F, 32'h04, "armed");
    repeat (6) @(posedge pclk);
    rd_chk(2'h1, 16'h001F, 32'h00, "arm clear");
    wr(2'h1, 16'h001F, 16'h0002);
    repeat (2) @(posedge pclk);
    check(busy, 1'b0, "unarmed");
    ee_rd(16'h0005, 32'hFF, "kept");
    $display("eeprom done");
  endtask
  task automatic t_rst();
    ee_start(16'h0007, 16'h00A5, 16'h0000);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    check(busy, 1'b1, "busy kept");
    ee_wait();
    wr(2'h1, 16'h0022, 16'h0001);
    ee_rd(16'h0007, 32'hA5, "after reset");
    gie <= 1'b1;
    wr(2'h1, 16'h001F, 16'h0008);
    repeat (2) @(posedge pclk);
    check(irq, 1'b1, "irq");
    ee_start(16'h0009, 16'h0001, 16'h0008);
    repeat (2) @(posedge pclk);
    check(irq, 1'b0, "irq busy");
    ee_wait();
    // self-programming blocks both a write start and the ready request
    selfprog <= 1'b1;
    ee_start(16'h0009, 16'h0002, 16'h0008);
    check(busy, 1'b0, "selfprog start");
    check(irq, 1'b0, "irq selfprog");
    selfprog <= 1'b0;
    gie <= 1'b0;
    repeat (2) @(posedge pclk);
    check(irq, 1'b0, "irq off");
    wr(2'h3, 16'h00FF, 16'hBEEF);
    target_pc <= 8'hFF;
    repeat (3) @(posedge pclk);
    check(fetch_word, 16'hBEEF, "fetch");
    apb(1'b0, 2'h3, 16'h0100, 16'h0000);
    check(e, 1'b1, "flash end");
    $display("reset and fetch done");
  endtask
  task automatic complete_run();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // watchdog at 20000 cycles, far beyond the expected run of under a thousand cycles
  initial begin
    #800000;
    errors++;
    complete_run();
  end
  initial begin
    {presetn, por_n, psel, penable, pwrite, gie, selfprog} = 7'h00;
    {paddr, pwdata, target_pc} = 60'h0;
    errors = 0;
    comparisons = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    por_n   <= 1'b1;
    t_map();
    t_ptr();
    t_ee();
    t_rst();
    complete_run();
  end
endmodule
`default_nettype wire
